// ---- dsi_pkg.sv ----
// constants and phasor tables for the doppler spectral integrator
// assumes a synchronous active-high reset and a single 20 MHz clock
package dsi_pkg;

	localparam int          DSI_LOG2N     = 5;
	localparam int          DSI_RANGES    = 16;
	localparam int          DSI_DW        = 16;
	localparam int          DSI_COEF_W    = 16;
	localparam int          DSI_FRAC      = 14;
	localparam int          DSI_CIRC_W    = 6;
	localparam int          DSI_FIFO_D    = 2;
	localparam int          DSI_CLK_MHZ   = 20;
	localparam logic [4:0]  DSI_QTR       = 5'h10;
	localparam logic [5:0]  DSI_QTR_IDX   = 6'h10;

	typedef logic signed [DSI_COEF_W-1:0] dsi_coef_type;

	localparam dsi_coef_type DSI_ONE = 16'sh4000;

	typedef enum logic {
		DSI_FILL,
		DSI_CALC
	} dsi_state_type;

	// first quarter of a 64-point sine, Q2.14
	function automatic dsi_coef_type dsi_qsin(input logic [4:0] j);
		case (j)
			5'h00: return 16'sh0000;
			5'h01: return 16'sh0646;
			5'h02: return 16'sh0C7C;
			5'h03: return 16'sh1294;
			5'h04: return 16'sh187E;
			5'h05: return 16'sh1E2B;
			5'h06: return 16'sh238E;
			5'h07: return 16'sh289A;
			5'h08: return 16'sh2D41;
			5'h09: return 16'sh3179;
			5'h0A: return 16'sh3537;
			5'h0B: return 16'sh3871;
			5'h0C: return 16'sh3B21;
			5'h0D: return 16'sh3D3F;
			5'h0E: return 16'sh3EC5;
			5'h0F: return 16'sh3FB1;
			default: return DSI_ONE;
		endcase
	endfunction : dsi_qsin

	// sine over a full 64-step circle
	function automatic dsi_coef_type dsi_sin(input logic [5:0] i);
		logic [4:0] j;
		j = i[4] ? 5'(DSI_QTR - {1'b0, i[3:0]}) : {1'b0, i[3:0]};
		return i[5] ? dsi_coef_type'(-dsi_qsin(j)) : dsi_qsin(j);
	endfunction : dsi_sin

	function automatic dsi_coef_type dsi_cos(input logic [5:0] i);
		return dsi_sin(6'(i + DSI_QTR_IDX));
	endfunction : dsi_cos

endpackage : dsi_pkg

// ---- dsi_fifo.sv ----
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module dsi_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wptr_reg;
	logic [PW-1:0] rptr_reg;
	logic [PW:0]   count_reg;
	logic          push;
	logic          pop;

	assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_reg[rptr_reg];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg == PW'(DEPTH-1)) ? '0 : PW'(wptr_reg + 1'b1);
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == PW'(DEPTH-1)) ? '0 : PW'(rptr_reg + 1'b1);
			end
			if (push && !pop) begin
				count_reg <= (PW+1)'(count_reg + 1'b1);
			end else if (pop && !push) begin
				count_reg <= (PW+1)'(count_reg - 1'b1);
			end
		end
	end

endmodule : dsi_fifo

// ---- dsi_integrator.sv ----
// doppler spectral integrator: range-by-pulse buffer, complex hanning
// window with half-line shift, then a direct dft per range row
// assumes samples arrive in range order per pulse, one clock domain
//
// Operation
// - integrate each range bin across pulses coherently
// - fill one column per pulse, lowest range first
// - compress first, then integrate before detection
// - one doppler spectrum per range bin
// - dft coefficients are unity-magnitude rotating phasors
// - line spacing 1/NT, span 1/T
// - hanning taper applied before the transform
// - window phase turns 180 degrees across record
// - full complex multiply, window before transform
`timescale 1ns/10ps
module dsi_integrator
	import dsi_pkg::*;
#(
	parameter int LOG2N  = dsi_pkg::DSI_LOG2N,
	parameter int RANGES = dsi_pkg::DSI_RANGES,
	parameter int DW     = dsi_pkg::DSI_DW,
	parameter int FIFO_D = dsi_pkg::DSI_FIFO_D
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          s_valid_i,
	output logic                               s_ready_o,
	input  wire logic signed [DW-1:0]          s_re_i,
	input  wire logic signed [DW-1:0]          s_im_i,
	output logic                               m_valid_o,
	input  wire logic                          m_ready_i,
	output logic signed [DW+LOG2N:0]           m_re_o,
	output logic signed [DW+LOG2N:0]           m_im_o,
	output logic [$clog2(RANGES)-1:0]          m_range_o,
	output logic [LOG2N-1:0]                   m_bin_o,
	output logic                               busy_o,
	output logic                               done_o
);
	import dsi_pkg::*;

	localparam int N     = 1 << LOG2N;
	localparam int RW    = (RANGES > 1) ? $clog2(RANGES) : 1;
	localparam int DEPTH = RANGES * N;
	localparam int AD    = $clog2(DEPTH);
	localparam int AW    = DW + LOG2N + 1;
	localparam int FW    = 2 * AW + RW + LOG2N;
	// angle step per pulse: a full turn per record, half for the window
	localparam int SH_F  = DSI_CIRC_W - LOG2N;
	localparam int SH_H  = SH_F - 1;
	localparam logic [LOG2N-1:0] NLAST = LOG2N'(N - 1);
	localparam logic [RW-1:0]    RLAST = RW'(RANGES - 1);

	dsi_state_type        state_reg;
	logic signed [DW-1:0] mem_re [DEPTH];
	logic signed [DW-1:0] mem_im [DEPTH];
	logic [RW-1:0]        fill_row_reg;
	logic [LOG2N-1:0]     fill_col_reg;
	logic [RW-1:0]        row_reg;
	logic [LOG2N-1:0]     bin_reg;
	logic [LOG2N-1:0]     pulse_reg;
	logic signed [AW-1:0] acc_re_reg;
	logic signed [AW-1:0] acc_im_reg;
	logic                 done_reg;
	logic                 accept;
	logic                 last_pulse;
	logic                 fifo_ready;
	logic                 step;
	logic [AD-1:0]        rd_addr;
	logic [AD-1:0]        wr_addr;
	logic signed [31:0]   x_re;
	logic signed [31:0]   x_im;
	logic signed [31:0]   h_amp;
	logic signed [31:0]   w_re;
	logic signed [31:0]   w_im;
	logic signed [31:0]   y_re;
	logic signed [31:0]   y_im;
	logic signed [31:0]   t_re;
	logic signed [31:0]   t_im;
	logic signed [31:0]   c_dft;
	logic signed [31:0]   s_dft;
	logic signed [31:0]   c_win;
	logic signed [31:0]   s_win;
	logic signed [31:0]   c_han;
	logic [5:0]           ang_win;
	logic [5:0]           ang_han;
	logic [5:0]           ang_dft;
	logic [LOG2N-1:0]     nk_mod;
	logic signed [AW-1:0] acc_re_next;
	logic signed [AW-1:0] acc_im_next;

	// input side: one column per pulse, lowest range first
	assign s_ready_o = (state_reg == DSI_FILL);
	assign accept    = s_valid_i && s_ready_o;
	assign wr_addr   = AD'(fill_col_reg * RANGES + fill_row_reg);
	assign rd_addr   = AD'(pulse_reg * RANGES + row_reg);

	// sample store has no reset; reads only follow a full record
	always_ff @(posedge clk_i) begin
		if (accept) begin
			mem_re[wr_addr] <= s_re_i;
			mem_im[wr_addr] <= s_im_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill_row_reg <= '0;
			fill_col_reg <= '0;
		end else if (accept) begin
			if (fill_row_reg == RLAST) begin
				fill_row_reg <= '0;
				fill_col_reg <= (fill_col_reg == NLAST) ? '0
					: LOG2N'(fill_col_reg + 1'b1);
			end else begin
				fill_row_reg <= RW'(fill_row_reg + 1'b1);
			end
		end
	end

	// window then dft, one pulse term per clock
	always_comb begin
		x_re    = 32'(mem_re[rd_addr]);
		x_im    = 32'(mem_im[rd_addr]);
		ang_han = 6'(pulse_reg << SH_F);
		ang_win = 6'(pulse_reg << SH_H);
		nk_mod  = LOG2N'(pulse_reg * bin_reg);
		ang_dft = 6'(nk_mod << SH_F);
		c_han   = 32'(dsi_cos(ang_han));
		c_win   = 32'(dsi_cos(ang_win));
		s_win   = 32'(dsi_sin(ang_win));
		c_dft   = 32'(dsi_cos(ang_dft));
		s_dft   = 32'(dsi_sin(ang_dft));
		h_amp   = (32'(DSI_ONE) - c_han) >>> 1;
		w_re    = (h_amp * c_win) >>> DSI_FRAC;
		w_im    = -((h_amp * s_win) >>> DSI_FRAC);
		y_re    = (x_re * w_re - x_im * w_im) >>> DSI_FRAC;
		y_im    = (x_re * w_im + x_im * w_re) >>> DSI_FRAC;
		t_re    = (y_re * c_dft + y_im * s_dft) >>> DSI_FRAC;
		t_im    = (y_im * c_dft - y_re * s_dft) >>> DSI_FRAC;
		acc_re_next = AW'(acc_re_reg + AW'(t_re));
		acc_im_next = AW'(acc_im_reg + AW'(t_im));
	end

	// a finished line waits for room in the output buffer
	assign last_pulse = (pulse_reg == NLAST);
	assign step       = (state_reg == DSI_CALC)
		&& (!last_pulse || fifo_ready);

	// the record ends only once its last line got into the buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= DSI_FILL;
		end else begin
			unique case (state_reg)
				DSI_FILL: begin
					if (accept && fill_row_reg == RLAST
						&& fill_col_reg == NLAST) begin
						state_reg <= DSI_CALC;
					end
				end
				DSI_CALC: begin
					if (step && last_pulse && bin_reg == NLAST
						&& row_reg == RLAST) begin
						state_reg <= DSI_FILL;
					end
				end
			endcase
		end
	end

	// one pulse term per clock; the sum restarts with each new bin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_reg  <= '0;
			bin_reg    <= '0;
			row_reg    <= '0;
			acc_re_reg <= '0;
			acc_im_reg <= '0;
		end else if (step) begin
			if (last_pulse) begin
				pulse_reg  <= '0;
				acc_re_reg <= '0;
				acc_im_reg <= '0;
				bin_reg    <= LOG2N'(bin_reg + 1'b1);
				if (bin_reg == NLAST) begin
					row_reg <= (row_reg == RLAST) ? '0
						: RW'(row_reg + 1'b1);
				end
			end else begin
				pulse_reg  <= LOG2N'(pulse_reg + 1'b1);
				acc_re_reg <= acc_re_next;
				acc_im_reg <= acc_im_next;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= step && last_pulse && bin_reg == NLAST
				&& row_reg == RLAST;
		end
	end

	assign done_o = done_reg;
	assign busy_o = (state_reg == DSI_CALC);

	// a full buffer freezes the row at its last pulse, losing nothing
	dsi_fifo #(
		.W     (FW),
		.DEPTH (FIFO_D)
	) u_out_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  ((state_reg == DSI_CALC) && last_pulse),
		.in_ready_o  (fifo_ready),
		.in_data_i   ({row_reg, bin_reg, acc_re_next, acc_im_next}),
		.out_valid_o (m_valid_o),
		.out_ready_i (m_ready_i),
		.out_data_o  ({m_range_o, m_bin_o, m_re_o, m_im_o})
	);

endmodule : dsi_integrator

// ---- dsi_integrator_props.sv ----
// checker on the integrator ports: fill/transform handshake, output order
// assumes one clock with synchronous active-high reset; bound below
`timescale 1ns/10ps
module dsi_integrator_props #(
	parameter int LOG2N  = 5,
	parameter int RANGES = 16,
	parameter int DW     = 16
) (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      s_ready_o,
	input wire logic                      m_valid_o,
	input wire logic                      m_ready_i,
	input wire logic signed [DW+LOG2N:0]  m_re_o,
	input wire logic signed [DW+LOG2N:0]  m_im_o,
	input wire logic [$clog2(RANGES)-1:0] m_range_o,
	input wire logic [LOG2N-1:0]          m_bin_o,
	input wire logic                      busy_o,
	input wire logic                      done_o
);
	localparam int N = 1 << LOG2N;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_rst_vals;
		disable iff (1'b0) rst_i |=> s_ready_o && !m_valid_o && !busy_o && !done_o;
	endproperty
	a_rst_vals: assert property (p_rst_vals)
		else $error("reset values wrong");
	property p_ready_busy;
		s_ready_o != busy_o;
	endproperty
	a_ready_busy: assert property (p_ready_busy)
		else $error("ready and busy overlap");
	property p_done_pulse;
		done_o |=> !done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than one cycle");
	property p_done_end;
		done_o |-> !busy_o && $past(busy_o);
	endproperty
	a_done_end: assert property (p_done_end)
		else $error("done without end of transform");
	property p_busy_fall;
		$fell(busy_o) |-> done_o;
	endproperty
	a_busy_fall: assert property (p_busy_fall)
		else $error("transform ended without done");
	property p_line_src;
		$rose(m_valid_o) |-> $past(busy_o);
	endproperty
	a_line_src: assert property (p_line_src)
		else $error("line outside transform");
	property p_hold;
		m_valid_o && !m_ready_i |=> m_valid_o && $stable(m_re_o)
			&& $stable(m_im_o) && $stable(m_bin_o) && $stable(m_range_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("line changed while stalled");
	property p_bin_step;
		(m_valid_o && m_ready_i && m_bin_o != N - 1) ##1 m_valid_o |->
			m_bin_o == $past(m_bin_o) + 1'b1 && m_range_o == $past(m_range_o);
	endproperty
	a_bin_step: assert property (p_bin_step)
		else $error("bin order wrong");
	property p_bin_wrap;
		(m_valid_o && m_ready_i && m_bin_o == N - 1) ##1 m_valid_o |->
			m_bin_o == 0;
	endproperty
	a_bin_wrap: assert property (p_bin_wrap)
		else $error("bin did not wrap");
endmodule : dsi_integrator_props
bind dsi_integrator dsi_integrator_props #(
	.LOG2N(LOG2N), .RANGES(RANGES), .DW(DW)
) props_u (
	.clk_i(clk_i), .rst_i(rst_i), .s_ready_o(s_ready_o),
	.m_valid_o(m_valid_o), .m_ready_i(m_ready_i), .m_re_o(m_re_o),
	.m_im_o(m_im_o), .m_range_o(m_range_o), .m_bin_o(m_bin_o),
	.busy_o(busy_o), .done_o(done_o)
);

// ---- dsi_src.sv ----
// upstream stage model: one record of compressed samples per go pulse
// assumes the integrator samples on the rising edge; drives 1 ns after it
`timescale 1ns/10ps
module dsi_src #(
	parameter int N      = 4,
	parameter int RANGES = 2
) (
	input  wire logic               clk_i,
	input  wire logic               go_i,
	input  wire logic               slow_i,
	input  wire logic signed [15:0] a_i,
	input  wire logic               s_ready_i,
	output logic                    s_valid_o,
	output logic signed [15:0]      s_re_o,
	output logic signed [15:0]      s_im_o
);
	int r, p;
	// released data inverted so a stale word never passes for a fresh one
	task automatic release_bus;
		s_valid_o = 1'b0;
		s_re_o = ~s_re_o;
		s_im_o = ~s_im_o;
	endtask : release_bus
	initial begin
		s_valid_o = 1'b0;
		s_re_o = 16'sh0000;
		s_im_o = 16'sh0000;
		forever begin
			@(posedge clk_i);
			if (go_i === 1'b1) begin
				for (int i = 0; i < N * RANGES; i++) begin
					r = i % RANGES;
					p = i / RANGES;
					#1 s_valid_o = 1'b1;
					s_re_o = p == 0 ? a_i : p == 2 ? 16'(a_i + r) : 16'sh0000;
					s_im_o = p == 0 ? a_i : p == 2 ? 16'(r - a_i) : 16'sh0000;
					do @(posedge clk_i); while (s_ready_i !== 1'b1);
					if (slow_i) begin
						#1 release_bus();
						@(posedge clk_i);
					end
				end
				#1 release_bus();
			end
		end
	end
endmodule : dsi_src

// ---- test_doppler_spectral_integrator.sv ----
// testbench: records with samples at pulses 0 and 2 per range through the integrator
// assumes dsi_src and the bound checker are compiled alongside
`timescale 1ns/10ps
module test_doppler_spectral_integrator;
	import dsi_pkg::*;
	localparam int N = 4;
	localparam int RG = 2;
	logic               clk_i = 0, rst_i = 1, go = 0, slow = 0;
	logic               m_ready_i = 0;
	logic signed [15:0] amp = 16'sh0100;
	logic               s_valid_i, s_ready_o, m_valid_o, busy_o, done_o;
	logic signed [15:0] s_re_i, s_im_i;
	logic signed [18:0] m_re_o, m_im_o;
	logic               m_range_o;
	logic [1:0]         m_bin_o;
	int                 fail_count = 0, compares = 0;
	dsi_integrator #(.LOG2N(2), .RANGES(RG)) dut_u (.clk_i(clk_i),
		.rst_i(rst_i), .s_valid_i(s_valid_i), .s_ready_o(s_ready_o),
		.s_re_i(s_re_i), .s_im_i(s_im_i), .m_valid_o(m_valid_o),
		.m_ready_i(m_ready_i), .m_re_o(m_re_o), .m_im_o(m_im_o),
		.m_range_o(m_range_o), .m_bin_o(m_bin_o), .busy_o(busy_o),
		.done_o(done_o));
	dsi_src #(.N(N), .RANGES(RG)) src_u (.clk_i(clk_i), .go_i(go),
		.slow_i(slow), .a_i(amp), .s_ready_i(s_ready_o),
		.s_valid_o(s_valid_i), .s_re_o(s_re_i), .s_im_o(s_im_i));
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	// only pulse 2 survives the taper; its spectrum alternates in sign
	task automatic run_record(input int stall);
		int n = 0, t = 0, d = 0, r, k, s, a;
		a = amp;
		go = 1;
		@(posedge clk_i);
		#1 go = 0;
		while (n < N * RG && t < 3000) begin
			@(posedge clk_i);
			if (m_valid_o === 1'b1 && m_ready_i === 1'b1) begin
				r = n / N;
				k = n % N;
				s = k % 2 ? -1 : 1;
				check("range", m_range_o, r);
				check("bin", m_bin_o, k);
				check("re", m_re_o, s * (r - a));
				check("im", m_im_o, -s * (a + r));
				n++;
			end
			d += done_o === 1'b1;
			#1 m_ready_i = t % (stall + 1) == 0;
			t++;
		end
		check("lines", n, N * RG);
		check("done", d, 1);
		check("idle", {busy_o, s_ready_o}, 2'b01);
	endtask : run_record
	task automatic reset_values;
		check("ready", s_ready_o, 1);
		check("state", {m_valid_o, busy_o, done_o}, 0);
	endtask : reset_values
	task automatic fast_record;
		run_record(0);
	endtask : fast_record
	task automatic slow_record;
		amp = 16'shF800;
		slow = 1;
		run_record(7);
	endtask : slow_record
	initial forever #25 clk_i = ~clk_i;
	initial begin
		repeat (4) @(posedge clk_i);
		#1 reset_values();
		rst_i = 0;
		fast_record();
		slow_record();
		final_report();
	end
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
endmodule : test_doppler_spectral_integrator
